// *** bench/swp_core_asserts.sv ***
`timescale 1ns/1ps
`include "swp_regs.svh"
module swp_core_asserts
  import swp_pkg::*;
(
  input wire logic CLOCK_I, // internal clock
  input wire logic RST_N_I, // synchronous reset, low active
  input wire logic SCS_N_I, // chip select, low active
  input wire logic CORE_DONE_I, // core completion pulse
  input wire logic CORE_REQ_O, // core request
  input wire swp_core_req_t CORE_O, // core access fields
  input wire logic WAIT_ACK_O, // handshake level
  input wire logic WAIT_ACK_OE_O, // handshake enable
  input wire logic WR_PENDING_O // posted write flag
);
  // ****************************************
  // Handshake and core port relations
  // ****************************************
  // Select is asynchronous, so the bounds allow for its two-flop sampling.
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  AST_OE_ON: assert property ($fell(SCS_N_I) |-> ##[1:5] WAIT_ACK_OE_O)
    else $error("handshake enable missing after select");
  AST_OE_OFF: assert property ($rose(SCS_N_I) |-> ##[1:5] !WAIT_ACK_OE_O)
    else $error("handshake enable kept after deselect");
  AST_SEL_WAIT: assert property ($rose(WAIT_ACK_OE_O) &&
    $past(WR_PENDING_O) && WR_PENDING_O |-> ##[0:1] !WAIT_ACK_O)
    else $error("select showed acknowledge with write pending");
  AST_REQ_HOLD: assert property ($past(CORE_REQ_O) && !$past(CORE_DONE_I)
    |-> CORE_REQ_O && $stable(CORE_O))
    else $error("core request dropped or changed early");
  AST_REQ_END: assert property (CORE_REQ_O && CORE_DONE_I |=> !CORE_REQ_O)
    else $error("core request held after completion");
  AST_ACK_DONE: assert property (CORE_REQ_O && CORE_DONE_I && !SCS_N_I
    |-> ##[1:6] (WAIT_ACK_O || SCS_N_I))
    else $error("no acknowledge after core completion");
  AST_BUSY_WAIT: assert property ($rose(CORE_REQ_O) ##3
    (CORE_REQ_O && !SCS_N_I) |-> !WAIT_ACK_O)
    else $error("acknowledge shown while core access open");
  AST_PEND_WR: assert property (CORE_REQ_O && CORE_O.wr |-> WR_PENDING_O)
    else $error("write in core without pending flag");
  AST_BE_SET: assert property (CORE_REQ_O && CORE_O.wr |-> CORE_O.be != 4'h0)
    else $error("core write with no byte lanes");
  AST_CORE_RANGE: assert property (CORE_REQ_O |-> CORE_O.addr <= `SWP_CORE_TOP)
    else $error("core access above core range");
endmodule : swp_core_asserts

bind swp_core swp_core_asserts u_asserts (
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .SCS_N_I(SCS_N_I),
  .CORE_DONE_I(CORE_DONE_I), .CORE_REQ_O(CORE_REQ_O), .CORE_O(CORE_O),
  .WAIT_ACK_O(WAIT_ACK_O), .WAIT_ACK_OE_O(WAIT_ACK_OE_O),
  .WR_PENDING_O(WR_PENDING_O)
);

// *** bench/swp_core_model.sv ***
`timescale 1ns/1ps
module swp_core_model
  import swp_pkg::*;
(
  input wire logic clk_i, // internal clock
  input wire logic rst_n_i, // synchronous reset, low active
  input wire logic req_i, // access request
  input wire swp_core_req_t core_i, // access fields
  input wire logic [5:0] lat_i, // cycles from request to completion
  output logic done_o, // one cycle completion pulse
  output logic [31:0] rdata_o // read data, valid with done
);
  // ****************************************
  // Arbitrated core port
  // ****************************************
  // Read data churns outside the done cycle, so a late capture is caught.
  logic [5:0] cnt_q;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !req_i || done_o)
    begin
      cnt_q <= 6'h0;
      done_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 6'h1;
      done_o <= (cnt_q == lat_i);
    end
    if (!rst_n_i)
      rdata_o <= 32'h0;
    else
      rdata_o <= (cnt_q == lat_i) ? {16'hC35A, core_i.addr} : ~rdata_o;
  end
endmodule : swp_core_model

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`include "swp_regs.svh"
module tb_top;
  import swp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sck = 1'b0;
  logic scs_n = 1'b1;
  logic sdi = 1'b0;
  logic cmd_valid = 1'b0;
  logic req_d = 1'b0;
  logic [5:0] lat = 6'h2;
  swp_cmd_t cmd = '0;
  swp_dummy_cfg_t dwr = '0;
  logic done, req, wa, wa_oe, pend, late, sdo, sdo_oe;
  logic [31:0] rdata;
  swp_core_req_t core;
  swp_core_req_t seen[$];
  swp_core_req_t exp_q[$];
  int failures = 0;
  int checks = 0;
  int seed = 70;
  int cycles = 0;

  swp_core u_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .SCK_I(sck),
    .SCS_N_I(scs_n), .SDI_I(sdi), .CMD_VALID_I(cmd_valid), .CMD_I(cmd),
    .DUMMY_WR_I(dwr), .DUMMY_RD_I('0), .DUMMY_LEN_I('0),
    .CORE_DONE_I(done), .CORE_RDATA_I(rdata), .CORE_REQ_O(req),
    .CORE_O(core), .WAIT_ACK_O(wa), .WAIT_ACK_OE_O(wa_oe), .SDO_O(sdo),
    .SDO_OE_O(sdo_oe), .WR_PENDING_O(pend), .LATE_O(late));
  swp_core_model u_core (.clk_i(clk), .rst_n_i(rst_n), .req_i(req),
    .core_i(core), .lat_i(lat), .done_o(done), .rdata_o(rdata));

  initial forever #4 clk = ~clk;

  always @(posedge clk)
  begin
    req_d <= req;
    if (req && !req_d)
      seen.push_back(core);
    cycles <= cycles + 1;
    if (cycles == 50000)
    begin
      failures++;
      end_sim();
    end
  end

  // ****************************************
  // Host side tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  task automatic chk_req(input swp_core_req_t e, input swp_core_req_t s);
    logic [31:0] m;
    for (int i = 0; i < 4; i++)
      m[i*8 +: 8] = {8{e.wr & e.be[i]}};
    chk("wr", {31'h0, e.wr}, {31'h0, s.wr});
    chk("addr", {16'h0, e.addr}, {16'h0, s.addr});
    chk("be", {28'h0, e.be}, {28'h0, s.be});
    chk("data", e.data & m, s.data & m);
  endtask : chk_req

  function automatic logic [15:0] exp_addr(input logic [1:0] st,
                                          input logic [15:0] a, input int k);
    case (st)
      `SWP_STEP_SAME: return a;
      `SWP_STEP_DEC: return a - 16'(k);
      default: return a + 16'(k);
    endcase
  endfunction : exp_addr

  task automatic bit_out(input logic b);
    sck = 1'b0;
    sdi = b;
    #41;
    sck = 1'b1;
    #39;
  endtask : bit_out

  task automatic byte_out(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      bit_out(b[i]);
  endtask : byte_out

  task automatic poll();
    for (int n = 0; n < 400 && wa !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk("ack", 32'h1, {31'h0, wa});
    @(posedge clk);
    #3;
  endtask : poll

  task automatic start(input swp_cmd_t c);
    @(posedge clk);
    #3;
    scs_n = 1'b0;
    #40;
    chk("oe", 32'h1, {31'h0, wa_oe});
    poll();
    cmd = c;
    cmd_valid = 1'b1;
    bit_out(1'b0);
    cmd_valid = 1'b0;
  endtask : start

  task automatic stop();
    sck = 1'b0;
    #40;
    scs_n = 1'b1;
    #40;
    chk("oe_off", 32'h0, {31'h0, wa_oe});
  endtask : stop

  task automatic idle();
    for (int n = 0; n < 400 && (pend !== 1'b0 || req !== 1'b0); n++)
    begin
      @(posedge clk);
      #1;
    end
    repeat (4) @(posedge clk);
    #3;
  endtask : idle

  task automatic wr_run(input logic [1:0] st, input int n);
    swp_cmd_t c;
    swp_core_req_t e;
    logic [15:0] x;
    logic [7:0] d;
    c = '0;
    c.is_wr = 1'b1;
    c.step = st;
    c.addr = 16'h0010 + 16'($random(seed) & 32'h1FFF);
    e = '0;
    e.wr = 1'b1;
    exp_q = {};
    seen = {};
    start(c);
    repeat (dwr.init) byte_out(8'($random(seed)));
    for (int k = 0; k < n; k++)
    begin
      if (k > 0)
        repeat (dwr.unit) byte_out(8'($random(seed)));
      d = 8'($random(seed));
      x = exp_addr(st, c.addr, k);
      byte_out(d);
      if (st != `SWP_STEP_DWORD)
      begin
        e.addr = x;
        e.be = 4'h1 << x[1:0];
        e.data = {4{d}};
        exp_q.push_back(e);
      end
      else
      begin
        e.addr = {x[15:2], 2'h0};
        e.be[x[1:0]] = 1'b1;
        e.data[x[1:0]*8 +: 8] = d;
        if (x[1:0] == 2'h3 || k == n - 1)
        begin
          exp_q.push_back(e);
          e.be = 4'h0;
        end
      end
      if ((st != `SWP_STEP_DWORD || x[1:0] == 2'h3) && lat < 6'd32)
      begin
        repeat (6) @(posedge clk);
        poll();
      end
    end
    stop();
    if (lat > 6'd31)
    begin
      #16;
      scs_n = 1'b0;
      #40;
      chk("sel_wait", 32'h0, {31'h0, wa});
      poll();
      scs_n = 1'b1;
    end
    idle();
    chk("late", 32'(lat > 6'd31), {31'h0, late});
    chk("count", exp_q.size(), seen.size());
    foreach (exp_q[i])
      if (i < seen.size())
        chk_req(exp_q[i], seen[i]);
  endtask : wr_run

  task automatic rd_run(input logic [15:0] a);
    swp_cmd_t c;
    swp_core_req_t e;
    logic [31:0] w;
    c = '0;
    c.plain = 1'b1;
    c.step = `SWP_STEP_INC;
    c.addr = a;
    e = '0;
    e.addr = a;
    e.be = 4'h1 << a[1:0];
    w = {16'hC35A, a};
    seen = {};
    start(c);
    repeat (6) @(posedge clk);
    poll();
    if (a <= `SWP_CORE_TOP)
      chk("sdo", {31'h0, w[a[1:0]*8 + 7]}, {31'h0, sdo});
    chk("sdo_oe", 32'(a <= `SWP_CORE_TOP), {31'h0, sdo_oe});
    byte_out(8'hFF);
    stop();
    idle();
    chk("rd_count", 32'(a <= `SWP_CORE_TOP), seen.size());
    if (seen.size() > 0)
      chk_req(e, seen[0]);
  endtask : rd_run

  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // ****************************************
  // Main sequence
  // ****************************************
  // The serial clock runs during and after reset so its domain leaves reset.
  initial
  begin
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (i == 0)
        dwr <= '{1'b0, 4'($random(seed) & 3), 4'($random(seed) & 1)};
      if (i == 10)
        rst_n <= 1'b1;
      #3;
      sck = ~sck;
    end
    chk("rst_req", 32'h0, {31'h0, req});
    chk("rst_pend", 32'h0, {31'h0, pend});
    chk("rst_late", 32'h0, {31'h0, late});
    chk("rst_oe", 32'h0, {31'h0, wa_oe});
    for (int s = 0; s < 4; s++)
      repeat (2)
      begin
        @(posedge clk);
        lat <= 6'($random(seed) & 15);
        wr_run(2'(s), 1 + ($random(seed) & 7));
        $display("test write step %0d done", s);
      end
    @(posedge clk);
    lat <= 6'd40;
    wr_run(`SWP_STEP_INC, 1);
    $display("test pending select done");
    @(posedge clk);
    lat <= 6'd9;
    rd_run(16'($random(seed) & 32'h1FFF));
    rd_run(16'h3000 + 16'($random(seed) & 32'hFF));
    $display("test reads done");
    end_sim();
  end
endmodule : tb_top

// *** src/swp_core.sv ***
`timescale 1ns/1ps
`include "swp_regs.svh"
module swp_core
  import swp_pkg::*;
(
  input wire logic CLOCK_I, // internal clock, 125 MHz
  input wire logic RST_N_I, // synchronous reset, low active
  input wire logic SCK_I, // serial clock from the host
  input wire logic SCS_N_I, // chip select, low active
  input wire logic SDI_I, // serial data in
  input wire logic CMD_VALID_I, // decoded command, serial domain
  input wire swp_cmd_t CMD_I, // decoded command fields
  input wire swp_dummy_cfg_t DUMMY_WR_I, // dummy bytes, writes
  input wire swp_dummy_cfg_t DUMMY_RD_I, // dummy bytes, plain read
  input wire swp_dummy_cfg_t DUMMY_LEN_I, // dummy bytes, length reads
  input wire logic CORE_DONE_I, // core access completed
  input wire logic [31:0] CORE_RDATA_I, // core read data
  output logic CORE_REQ_O, // core access request
  output swp_core_req_t CORE_O, // core access fields
  output logic WAIT_ACK_O, // 1 acknowledge, 0 wait
  output logic WAIT_ACK_OE_O, // handshake pin enable
  output logic SDO_O, // serial data out
  output logic SDO_OE_O, // serial data out enable
  output logic WR_PENDING_O, // posted write outstanding
  output logic LATE_O // last core access overran budget
);

  // ***************************************************************
  // Crossings into the serial clock domain
  // ***************************************************************
  logic rst_sck_n;
  swp_dummy_cfg_t cfg_wr_s, cfg_rd_s, cfg_len_s;

  swp_sync #(.WIDTH(1)) u_rst_sck (
    .clk_i(SCK_I),
    .rst_n_i(1'b1),
    .d_i(RST_N_I),
    .q_o(rst_sck_n)
  );

  // Dummy settings are quasi-static; software changes them between frames.
  swp_sync #(.WIDTH(3 * $bits(swp_dummy_cfg_t))) u_cfg_sck (
    .clk_i(SCK_I),
    .rst_n_i(rst_sck_n),
    .d_i({DUMMY_WR_I, DUMMY_RD_I, DUMMY_LEN_I}),
    .q_o({cfg_wr_s, cfg_rd_s, cfg_len_s})
  );

  // ***************************************************************
  // Serial domain: data phase
  // ***************************************************************
  swp_sck_state_t state_s;
  swp_dummy_cfg_t cfg_s;
  swp_core_req_t hold_s, rreq_s;
  logic [15:0] addr_s, rem_s;
  logic [1:0] step_s, lane_s;
  logic [2:0] bitc_s;
  logic [3:0] skip_s, wbe_s;
  logic [6:0] sh_s;
  logic [31:0] wdat_s, cur_s;
  logic plain_s, dwm_s, wtog_s, rtog_s, ftog_s, wrf_s;
  logic sdo_s, ustart_s, ract_s;
  logic [31:0] rdata_c;

  logic [7:0] byte_in;
  logic [31:0] wdat_n, src_word;
  logic [3:0] be_n;
  logic [15:0] addr_step;
  logic [2:0] bit_n;
  logic byte_end, dw_end, unit_end;

  function automatic logic [3:0] len_be(input logic [1:0] off,
                                        input logic [15:0] rem);
    logic [3:0] m;
    m = 4'hF << off;
    if (rem < 16'h0003)
      m = m & ~(4'hF << (rem[1:0] + off));
    len_be = m;
  endfunction : len_be

  always_comb
  begin
    byte_in = {sh_s, SDI_I};
    wdat_n = wdat_s;
    wdat_n[addr_s[1:0]*8 +: 8] = byte_in;
    be_n = wbe_s | (4'h1 << addr_s[1:0]);
    byte_end = (bitc_s == `SWP_BIT_LAST);
    dw_end = byte_end && (addr_s[1:0] == `SWP_LANE_LAST);
    unit_end = cfg_s.per_dw ? dw_end : byte_end;
    unique case (step_s)
      `SWP_STEP_INC: addr_step = addr_s + 16'h0001;
      `SWP_STEP_DEC: addr_step = addr_s - 16'h0001;
      `SWP_STEP_DWORD: addr_step = addr_s + 16'h0001;
      `SWP_STEP_SAME: addr_step = addr_s;
    endcase
    bit_n = `SWP_BIT_LAST - (bitc_s + 3'h1);
    src_word = ustart_s ? rdata_c : cur_s;
  end

  always_ff @(posedge SCK_I)
  begin
    if (!rst_sck_n)
    begin
      state_s <= S_IDLE;
      cfg_s <= '0;
      hold_s <= '0;
      rreq_s <= '0;
      addr_s <= '0;
      rem_s <= '0;
      step_s <= `SWP_STEP_SAME;
      lane_s <= '0;
      bitc_s <= '0;
      skip_s <= '0;
      wbe_s <= '0;
      sh_s <= '0;
      wdat_s <= '0;
      cur_s <= '0;
      plain_s <= 1'b0;
      dwm_s <= 1'b0;
      wtog_s <= 1'b0;
      rtog_s <= 1'b0;
      ftog_s <= 1'b0;
      wrf_s <= 1'b0;
      sdo_s <= 1'b0;
      ustart_s <= 1'b0;
      ract_s <= 1'b0;
    end
    else if (CMD_VALID_I)
    begin
      cfg_s <= CMD_I.is_wr ? cfg_wr_s :
               (CMD_I.plain ? cfg_rd_s : cfg_len_s);
      skip_s <= CMD_I.is_wr ? cfg_wr_s.init :
                (CMD_I.plain ? cfg_rd_s.init : cfg_len_s.init);
      bitc_s <= '0;
      wbe_s <= '0;
      step_s <= CMD_I.step;
      plain_s <= CMD_I.plain;
      dwm_s <= CMD_I.is_wr && (CMD_I.step == `SWP_STEP_DWORD);
      ftog_s <= ~ftog_s;
      wrf_s <= CMD_I.is_wr;
      ustart_s <= ~CMD_I.is_wr;
      ract_s <= 1'b0;
      if (CMD_I.addr > `SWP_CORE_TOP)
        state_s <= S_IDLE;
      else if (CMD_I.is_wr)
      begin
        state_s <= S_WR;
        addr_s <= CMD_I.addr;
      end
      else
      begin
        state_s <= S_RD;
        rtog_s <= ~rtog_s;
        if (CMD_I.plain)
        begin
          rreq_s <= '{wr: 1'b0, addr: CMD_I.addr,
                      be: 4'h1 << CMD_I.addr[1:0], data: '0};
          lane_s <= CMD_I.addr[1:0];
          addr_s <= CMD_I.addr;
        end
        else
        begin
          // Padding lanes below the start offset keep output aligned.
          rreq_s <= '{wr: 1'b0, addr: {CMD_I.addr[15:2], 2'h0},
                      be: len_be(CMD_I.addr[1:0], CMD_I.len),
                      data: '0};
          lane_s <= '0;
          addr_s <= {CMD_I.addr[15:2], 2'h0};
          rem_s <= (CMD_I.len > 16'h0004 - {14'h0, CMD_I.addr[1:0]}) ?
                   CMD_I.len - (16'h0004 - {14'h0, CMD_I.addr[1:0]}) :
                   16'h0000;
        end
      end
    end
    else if (skip_s != 4'h0)
    begin
      // Dummy bytes only pace the host; their bits are discarded.
      bitc_s <= bitc_s + 3'h1;
      if (byte_end)
      begin
        skip_s <= skip_s - 4'h1;
        ract_s <= (skip_s == 4'h1) && (state_s == S_RD);
      end
    end
    else
    begin
      unique case (state_s)
        S_WR:
        begin
          sh_s <= byte_in[6:0];
          bitc_s <= bitc_s + 3'h1;
          if (byte_end)
          begin
            addr_s <= addr_step;
            if (unit_end)
              skip_s <= cfg_s.unit;
            if (!dwm_s)
            begin
              hold_s <= '{wr: 1'b1, addr: addr_s,
                          be: 4'h1 << addr_s[1:0],
                          data: {4{byte_in}}};
              wtog_s <= ~wtog_s;
            end
            else if (dw_end)
            begin
              hold_s <= '{wr: 1'b1, addr: {addr_s[15:2], 2'h0},
                          be: be_n, data: wdat_n};
              wtog_s <= ~wtog_s;
              wbe_s <= '0;
            end
            else
            begin
              wdat_s <= wdat_n;
              wbe_s <= be_n;
            end
          end
        end
        S_RD:
        begin
          bitc_s <= bitc_s + 3'h1;
          ract_s <= 1'b1;
          sdo_s <= src_word[{lane_s, bit_n}];
          if (ustart_s)
          begin
            // This edge follows the first output bit of the unit.
            cur_s <= rdata_c;
            ustart_s <= 1'b0;
            if (plain_s && !SDI_I)
            begin
              rreq_s <= '{wr: 1'b0, addr: addr_step,
                          be: 4'h1 << addr_step[1:0], data: '0};
              rtog_s <= ~rtog_s;
              addr_s <= addr_step;
            end
            else if (!plain_s && (rem_s != 16'h0000))
            begin
              rreq_s <= '{wr: 1'b0,
                          addr: (step_s == `SWP_STEP_DEC) ?
                                addr_s - 16'h0004 :
                                ((step_s == `SWP_STEP_SAME) ?
                                 addr_s : addr_s + 16'h0004),
                          be: len_be(2'h0, rem_s), data: '0};
              rtog_s <= ~rtog_s;
              addr_s <= (step_s == `SWP_STEP_DEC) ? addr_s - 16'h0004 :
                        ((step_s == `SWP_STEP_SAME) ?
                         addr_s : addr_s + 16'h0004);
              rem_s <= (rem_s > 16'h0004) ? rem_s - 16'h0004 : 16'h0000;
            end
          end
          if (byte_end)
          begin
            lane_s <= plain_s ? addr_s[1:0] : lane_s + 2'h1;
            if (plain_s || (lane_s == `SWP_LANE_LAST))
            begin
              ustart_s <= 1'b1;
              skip_s <= cfg_s.unit;
              ract_s <= (cfg_s.unit == 4'h0);
            end
          end
        end
        default:
        begin
          bitc_s <= '0;
        end
      endcase
    end
  end

  // ***************************************************************
  // Crossings into the internal clock domain
  // ***************************************************************
  logic cs_n_c, wtog_c, rtog_c;
  swp_link_stat_t st_c;

  swp_sync #(.WIDTH(3)) u_ev_clk (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .d_i({SCS_N_I, wtog_s, rtog_s}),
    .q_o({cs_n_c, wtog_c, rtog_c})
  );

  // Status bits settle between serial edges, far slower than two clocks.
  swp_sync #(.WIDTH($bits(swp_link_stat_t))) u_st_clk (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .d_i({state_s == S_RD, ract_s, ustart_s, sdo_s, lane_s, ftog_s,
          wrf_s}),
    .q_o(st_c)
  );

  // ***************************************************************
  // Internal domain: posted writes, read fetches, core port
  // ***************************************************************
  swp_core_state_t cst_q;
  swp_core_req_t wreq_q, rreq_q;
  logic wtog_q, rtog_q, cs_n_q, ftog_done_q;
  logic wr_pend_q, rd_pend_q;
  logic [9:0] cnt_q, budget_q;
  logic wr_ev, rd_ev, part_ev, issue_wr, issue_rd;

  function automatic logic [2:0] pop4(input logic [3:0] v);
    pop4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction : pop4

  always_comb
  begin
    wr_ev = (wtog_c != wtog_q);
    rd_ev = (rtog_c != rtog_q);
    // The serial clock has stopped, so the partial buffer is stable here.
    part_ev = cs_n_c && !cs_n_q && st_c.wrf && (wbe_s != 4'h0) &&
              (st_c.ftog != ftog_done_q);
    issue_wr = (cst_q == C_IDLE) && wr_pend_q;
    issue_rd = (cst_q == C_IDLE) && !wr_pend_q && rd_pend_q;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      wtog_q <= 1'b0;
      rtog_q <= 1'b0;
      cs_n_q <= 1'b1;
      ftog_done_q <= 1'b0;
    end
    else
    begin
      wtog_q <= wtog_c;
      rtog_q <= rtog_c;
      cs_n_q <= cs_n_c;
      if (part_ev)
        ftog_done_q <= st_c.ftog;
    end
  end

  // A new event in the issue cycle sets the flag again: set wins.
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wreq_q <= '0;
      rreq_q <= '0;
    end
    else
    begin
      if (wr_ev)
        wreq_q <= hold_s;
      else if (part_ev)
        wreq_q <= '{wr: 1'b1, addr: {addr_s[15:2], 2'h0},
                    be: wbe_s, data: wdat_s};
      if (rd_ev)
        rreq_q <= rreq_s;
      wr_pend_q <= wr_ev || part_ev || (wr_pend_q && !issue_wr);
      rd_pend_q <= rd_ev || (rd_pend_q && !issue_rd);
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      cst_q <= C_IDLE;
      CORE_REQ_O <= 1'b0;
      CORE_O <= '0;
      rdata_c <= '0;
    end
    else
    begin
      unique case (cst_q)
        C_IDLE:
        begin
          if (issue_wr || issue_rd)
          begin
            cst_q <= C_BUSY;
            CORE_REQ_O <= 1'b1;
            CORE_O <= issue_wr ? wreq_q : rreq_q;
          end
        end
        C_BUSY:
        begin
          if (CORE_DONE_I)
          begin
            cst_q <= C_IDLE;
            CORE_REQ_O <= 1'b0;
            if (!CORE_O.wr)
              for (int i = 0; i < 4; i++)
                rdata_c[i*8 +: 8] <= CORE_O.be[i] ?
                                     CORE_RDATA_I[i*8 +: 8] : 8'h00;
          end
        end
      endcase
    end
  end

  // Access budget monitor; the core port decides the real timing.
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      cnt_q <= '0;
      budget_q <= '0;
      LATE_O <= 1'b0;
    end
    else if (issue_wr)
    begin
      cnt_q <= '0;
      LATE_O <= 1'b0;
      budget_q <= 10'(`SWP_WR_BYTE_CYC) +
                  10'((pop4(wreq_q.be) - 3'h1) * `SWP_WR_EXTRA_CYC);
    end
    else if (issue_rd)
    begin
      cnt_q <= '0;
      LATE_O <= 1'b0;
      budget_q <= (rreq_q.be == (4'h1 << rreq_q.addr[1:0])) ?
                  10'(`SWP_RD_PLAIN_CYC) : 10'(`SWP_RD_LEN_CYC);
    end
    else if (cst_q == C_BUSY)
    begin
      cnt_q <= cnt_q + 10'h001;
      if ((cnt_q >= budget_q) && !CORE_DONE_I)
        LATE_O <= 1'b1;
    end
  end

  // ***************************************************************
  // Pin outputs
  // ***************************************************************
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      WAIT_ACK_O <= 1'b1;
      WAIT_ACK_OE_O <= 1'b0;
      SDO_O <= 1'b0;
      SDO_OE_O <= 1'b0;
      WR_PENDING_O <= 1'b0;
    end
    else
    begin
      WAIT_ACK_OE_O <= !cs_n_c;
      // Wait comes only from outstanding core work and newly arrived write or read events.
      WAIT_ACK_O <= !(wr_pend_q || rd_pend_q || (cst_q == C_BUSY) ||
                      wr_ev || rd_ev);
      WR_PENDING_O <= wr_pend_q || (cst_q == C_BUSY && CORE_O.wr);
      SDO_OE_O <= !cs_n_c && st_c.rdf;
      if (!st_c.ract && !st_c.ustart)
        SDO_O <= 1'b0;
      else if (st_c.ustart)
        SDO_O <= (rd_pend_q || (cst_q == C_BUSY)) ? 1'b0 :
                 rdata_c[{st_c.lane, `SWP_BIT_LAST}];
      else
        SDO_O <= st_c.sdo;
    end
  end

endmodule : swp_core

// *** src/swp_pkg.sv ***
package swp_pkg;

  typedef enum logic [1:0] {S_IDLE, S_WR, S_RD} swp_sck_state_t;

  typedef enum logic {C_IDLE, C_BUSY} swp_core_state_t;

  typedef struct packed {
    logic per_dw;
    logic [3:0] init;
    logic [3:0] unit;
  } swp_dummy_cfg_t;

  typedef struct packed {
    logic is_wr;
    logic plain;
    logic [1:0] step;
    logic [15:0] addr;
    logic [15:0] len;
  } swp_cmd_t;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] data;
  } swp_core_req_t;

  typedef struct packed {
    logic rdf;
    logic ract;
    logic ustart;
    logic sdo;
    logic [1:0] lane;
    logic ftog;
    logic wrf;
  } swp_link_stat_t;

endpackage : swp_pkg

// *** src/swp_regs.svh ***
// Functional notes
// - Core write per byte, or per doubleword.
// - Chip select release commits partial doubleword.
// - Step code 11 selects doubleword buffering.
// - Byte steps: 00 same, 01 up, 10 down.
// - Doubleword mode increments, lanes rise, short start.
// - Core write within 250 ns plus 80/extra byte.
// - Plain read next byte within 370 ns.
// - Length reads: next doubleword within 610 ns.
// - Configurable dummy bytes: initial, per byte/doubleword.
// - Handshake driven while selected, released otherwise.
// - Select shows wait if write still pending.
// - Core reads show wait until data arrives.
// - Wait again during prefetch, else hold acknowledge.
// - Early first bit appears once data arrives.
// - Writes: wait per unit until core completes.
// - Length reads prepend alignment padding bytes.
`ifndef SWP_REGS_SVH
`define SWP_REGS_SVH

`define SWP_STEP_SAME 2'h0
`define SWP_STEP_INC 2'h1
`define SWP_STEP_DEC 2'h2
`define SWP_STEP_DWORD 2'h3

`define SWP_CORE_TOP 16'h2FFF

`define SWP_CLK_NS 8
`define SWP_WR_BYTE_NS 250
`define SWP_WR_EXTRA_NS 80
`define SWP_RD_PLAIN_NS 370
`define SWP_RD_LEN_NS 610
`define SWP_HOST_DW_NS 490

`define SWP_WR_BYTE_CYC (`SWP_WR_BYTE_NS / `SWP_CLK_NS)
`define SWP_WR_EXTRA_CYC (`SWP_WR_EXTRA_NS / `SWP_CLK_NS)
`define SWP_RD_PLAIN_CYC (`SWP_RD_PLAIN_NS / `SWP_CLK_NS)
`define SWP_RD_LEN_CYC (`SWP_RD_LEN_NS / `SWP_CLK_NS)

`define SWP_LANE_LAST 2'h3
`define SWP_BIT_LAST 3'h7

`endif

// *** src/swp_sync.sv ***
`timescale 1ns/1ps
module swp_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_i, // destination clock
  input wire logic rst_n_i, // synchronous reset, low active
  input wire logic [WIDTH-1:0] d_i, // asynchronous level
  output logic [WIDTH-1:0] q_o // synchronised level
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule : swp_sync
